// ===== spidsf_frontend.sv
/*
 Serial slave front end with global fault indicator, global status byte, in-frame
 response, protocol error detection and daisy-chain forwarding.
 Assumes a master with clock idle low; the serial clock runs only inside frames,
 and chip select and serial input change in step with that clock.
*/
//
// Summary of operation
// - Before first rise, output is fault OR input.
// - Fault indicator shows faults and fresh power-up.
// - Clockless frame is a harmless fault poll.
// - First eight clocks shift out status byte.
// - Load error is OR of load failures.
// - Fault indicator ORs status bits, inverted powerup.
// - Powerup flag starts at zero, indicator one.
// - Protocol error appears in status bit seven next frame.
// - Bad clock count flags protocol error.
// - Unused register address flags protocol error.
// - Address byte with low bit zero is error.
// - Missing last-address marker flags protocol error.
// - Clock high at select edges is error.
// - Bits six to two select register, bit seven operation.
// - Address byte time returns indicator then status.
// - Data byte time returns addressed register contents.
// - Chain forwards status and response bytes onward.
// - Sample on falling edge, drive on rising.
// - Act after deselect; output released when deselected.
// - Operation bit one writes controls, clears status.
// - Status bits clear only on explicit command.
`timescale 1ns/1ps
module spidsf_frontend
	import spidsf_pkg::*;
#(
	parameter int CTRL_N = 8,
	parameter int LOAD_N = 4
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Serial link
	input wire logic serial_clk_i,
	input wire logic chip_select_n_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_n_o,
	// Fault sources
	input wire logic supply_undervoltage_i,
	input wire logic supply_overvoltage_i,
	input wire logic thermal_shutdown_i,
	input wire logic thermal_warning_i,
	input wire logic [LOAD_N-1:0] open_load_failure_i,
	input wire logic [LOAD_N-1:0] overcurrent_failure_i,
	// Register contents and status
	output logic [CTRL_N-1:0][BYTE_W-1:0] ctrl_o,
	output logic [BYTE_W-1:0] global_status_o,
	output logic global_fault_indicator_o
);
	localparam int SYNC_W = 7 + 2 * LOAD_N;
	localparam int LF_W = 2 * LOAD_N;

	generate
		if (CTRL_N < 1 || CTRL_N > int'(GSTAT_IDX) || LOAD_N < 1 || 2 * LOAD_N > BYTE_W) begin : g_bad
			$error("spidsf_frontend: CTRL_N or LOAD_N out of range");
		end
	endgenerate

	function automatic logic reg_used(input logic [IDX_W-1:0] idx);
		reg_used = (int'(idx) < CTRL_N) || (idx == GSTAT_IDX) || (idx == LOADST_IDX);
	endfunction

	function automatic logic [IDX_W-1:0] reg_index(input logic [BYTE_W-1:0] addr);
		reg_index = addr[IDX_HI_BIT:IDX_LO_BIT];
	endfunction

	// Link domain, falling edge: receive side.
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [BYTE_W-1:0] shift;
		logic addr_done;
		logic [BYTE_W-1:0] addr_byte;
		logic [BYTE_W-1:0] data_byte;
		logic lsb_err;
	} spidsf_rx_s;

	// Link domain, rising edge: transmit side.
	typedef struct packed {
		logic started;
		spidsf_tx_e st;
		logic [2:0] bit_idx;
		logic [BYTE_W-1:0] shreg;
		logic sdo;
	} spidsf_tx_s;

	// Reference domain.
	typedef struct packed {
		logic csn_d;
		logic saw_clk;
		logic pol_err;
		logic pwrup_done;
		logic global_fault_indicator;
		logic [CTRL_N-1:0][BYTE_W-1:0] ctrl;
		logic [NUM_REGS-1:0][BYTE_W-1:0] snap;
	} spidsf_sys_s;

	localparam spidsf_sys_s SYS_RESET = '{
		csn_d: 1'b1,
		saw_clk: 1'b0,
		pol_err: 1'b0,
		pwrup_done: 1'b0,
		global_fault_indicator: 1'b1,
		ctrl: {CTRL_N{CTRL_RESET}},
		snap: '0
	};

	spidsf_rx_s rx;
	spidsf_rx_s rx_cur;
	spidsf_rx_s next_rx;
	logic rx_armed;
	spidsf_tx_s tx;
	spidsf_tx_s next_tx;
	spidsf_sys_s sys;
	spidsf_sys_s next_sys;

	logic [SYNC_W-1:0] sync_q;
	logic csn_s;
	logic sclk_s;
	logic armed_s;
	logic [GF_W-1:0] gflag;
	logic [GF_W-1:0] gflag_set;
	logic [GF_W-1:0] gflag_clr;
	logic [LF_W-1:0] lflag;
	logic [LF_W-1:0] lflag_set;
	logic [LF_W-1:0] lflag_clr;
	logic frame_start;
	logic frame_end;
	logic count_bad;
	logic addr_bad;
	logic proto_err;
	logic execute;
	logic [IDX_W-1:0] exec_idx;
	logic load_any;
	logic [BYTE_W-1:0] gstat_live;
	logic [BYTE_W-1:0] resp_byte;

	// The armed flag marks the first falling edge of a frame; it is cleared by deselect
	// so that the receive state needs no reset of its own and survives until read.
	always_ff @(negedge serial_clk_i or posedge chip_select_n_i) begin
		if (chip_select_n_i) begin
			rx_armed <= 1'b0;
		end else begin
			rx_armed <= 1'b1;
		end
	end

	always_comb begin
		rx_cur = rx_armed ? rx : '0;
		next_rx = rx;
		if (!chip_select_n_i) begin
			next_rx = rx_cur;
			if (rx_cur.cnt != '1) begin
				next_rx.cnt = rx_cur.cnt + CNT_ONE;
			end
			next_rx.shift = {serial_in_i, rx_cur.shift[BYTE_W-1:1]};
			if (rx_cur.cnt[2:0] == LAST_BIT_OF_BYTE) begin
				if (!rx_cur.addr_done) begin
					if (!next_rx.shift[ADDR_LSB_BIT]) begin
						next_rx.lsb_err = 1'b1;
					end
					if (next_rx.shift[LAST_ADDRESS_MARKER_BIT]) begin
						next_rx.addr_done = 1'b1;
						next_rx.addr_byte = next_rx.shift;
					end
				end else begin
					next_rx.data_byte = next_rx.shift;
				end
			end
		end
	end

	always_ff @(negedge serial_clk_i) begin
		rx <= next_rx;
	end

	// Response contents come from the snapshot, which is frozen while selected.
	assign resp_byte = sys.snap[reg_index(rx.addr_byte)];

	always_comb begin
		next_tx = tx;
		next_tx.started = 1'b1;
		unique case (tx.st)
			TX_STAT: begin
				next_tx.sdo = sys.snap[GSTAT_IDX][tx.bit_idx];
				next_tx.bit_idx = tx.bit_idx + 3'h1;
				if (tx.bit_idx == LAST_BIT_OF_BYTE) begin
					next_tx.st = TX_WAIT;
				end
			end
			TX_WAIT: begin
				if (rx_armed && rx.addr_done) begin
					next_tx.sdo = resp_byte[0];
					next_tx.shreg = resp_byte >> 1;
					next_tx.bit_idx = 3'h1;
					next_tx.st = TX_RESP;
				end else begin
					next_tx.sdo = rx.shift[0];
				end
			end
			TX_RESP: begin
				next_tx.sdo = tx.shreg[0];
				next_tx.shreg = tx.shreg >> 1;
				next_tx.bit_idx = tx.bit_idx + 3'h1;
				if (tx.bit_idx == LAST_BIT_OF_BYTE) begin
					next_tx.st = TX_DONE;
				end
			end
			TX_DONE: begin
				next_tx.sdo = rx.shift[0];
			end
		endcase
	end

	always_ff @(posedge serial_clk_i or posedge chip_select_n_i) begin
		if (chip_select_n_i) begin
			tx <= '0;
		end else begin
			tx <= next_tx;
		end
	end

	// Before the first rising edge the fault indicator is ORed with the chain input.
	assign serial_out_o = tx.started ? tx.sdo : (sys.global_fault_indicator | serial_in_i);
	assign serial_out_oe_n_o = chip_select_n_i;

	spidsf_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_i(ref_clk_i),
		.reset_i(reset_i),
		.d_i({overcurrent_failure_i, open_load_failure_i, thermal_warning_i, thermal_shutdown_i,
			supply_overvoltage_i, supply_undervoltage_i, rx_armed, serial_clk_i,
			!chip_select_n_i}),
		.q_o(sync_q)
	);

	// Select enters inverted so that a cleared synchroniser reads as deselected after reset.
	assign csn_s = !sync_q[0];
	assign sclk_s = sync_q[1];
	assign armed_s = sync_q[2];

	assign frame_start = !csn_s && sys.csn_d;
	assign frame_end = csn_s && !sys.csn_d;

	// Receive state is quiet once deselected, so it is read as a settled word here.
	always_comb begin
		count_bad = sys.saw_clk && ((rx.cnt[2:0] != 3'h0) || (rx.cnt < MIN_FRAME_CLKS));
		addr_bad = sys.saw_clk && (rx.lsb_err || !rx.addr_done
			|| !reg_used(reg_index(rx.addr_byte)));
		proto_err = count_bad || addr_bad || sys.pol_err || sclk_s;
		execute = frame_end && sys.saw_clk && !proto_err && rx.addr_byte[OP_BIT];
		exec_idx = reg_index(rx.addr_byte);
	end

	always_comb begin
		gflag_set = '0;
		gflag_set[GF_UV] = sync_q[3];
		gflag_set[GF_OV] = sync_q[4];
		gflag_set[GF_TSD] = sync_q[5];
		gflag_set[GF_TPW] = sync_q[6];
		gflag_set[GF_PROTO] = frame_end && proto_err;
		lflag_set = sync_q[SYNC_W-1:7];
		gflag_clr = (execute && exec_idx == GSTAT_IDX) ? '1 : '0;
		lflag_clr = (execute && exec_idx == LOADST_IDX) ? '1 : '0;
	end

	spidsf_sticky #(
		.W(GF_W),
		.RESET_VAL(GFLAG_RESET)
	) u_gflags (
		.clk_i(ref_clk_i),
		.reset_i(reset_i),
		.set_i(gflag_set),
		.clr_i(gflag_clr),
		.flag_o(gflag)
	);

	spidsf_sticky #(
		.W(LF_W),
		.RESET_VAL('0)
	) u_lflags (
		.clk_i(ref_clk_i),
		.reset_i(reset_i),
		.set_i(lflag_set),
		.clr_i(lflag_clr),
		.flag_o(lflag)
	);

	assign load_any = |lflag;

	always_comb begin
		gstat_live = '0;
		gstat_live[GS_PROTO] = gflag[GF_PROTO];
		gstat_live[GS_LOAD] = load_any;
		gstat_live[GS_UV] = gflag[GF_UV];
		gstat_live[GS_OV] = gflag[GF_OV];
		gstat_live[GS_PWRUP] = sys.pwrup_done;
		gstat_live[GS_TSD] = gflag[GF_TSD];
		gstat_live[GS_TPW] = gflag[GF_TPW];
	end

	always_comb begin
		next_sys = sys;
		next_sys.csn_d = csn_s;
		next_sys.global_fault_indicator = (|gflag) || load_any || !sys.pwrup_done;
		if (frame_start) begin
			next_sys.saw_clk = 1'b0;
			next_sys.pol_err = sclk_s;
		end else if (!csn_s && armed_s) begin
			next_sys.saw_clk = 1'b1;
		end
		if (execute) begin
			if (int'(exec_idx) < CTRL_N) begin
				next_sys.ctrl[exec_idx] = rx.data_byte;
			end
			if (exec_idx == GSTAT_IDX) begin
				next_sys.pwrup_done = 1'b1;
			end
		end
		// The snapshot only moves while deselected, so the link never sees it change.
		if (csn_s && sys.csn_d) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				next_sys.snap[i] = '0;
			end
			for (int i = 0; i < CTRL_N; i++) begin
				next_sys.snap[i] = sys.ctrl[i];
			end
			next_sys.snap[GSTAT_IDX] = gstat_live;
			next_sys.snap[LOADST_IDX] = BYTE_W'(lflag);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sys <= SYS_RESET;
		end else begin
			sys <= next_sys;
		end
	end

	assign ctrl_o = sys.ctrl;
	assign global_status_o = sys.snap[GSTAT_IDX];
	assign global_fault_indicator_o = sys.global_fault_indicator;
endmodule

// ===== spidsf_pkg.sv
/*
 Shared constants for the serial front end: address byte layout, register indices,
 global status bit positions, reset values and the transmit sequence states.
 Assumes an eight-bit register space reached by a 16-bit or daisy-chained frame.
*/
package spidsf_pkg;
	localparam int BYTE_W = 8;
	localparam int IDX_W = 5;
	localparam int NUM_REGS = 32;
	localparam int CNT_W = 16;
	localparam int ADDR_LSB_BIT = 0;
	localparam int LAST_ADDRESS_MARKER_BIT = 1;
	localparam int IDX_LO_BIT = 2;
	localparam int IDX_HI_BIT = 6;
	localparam int OP_BIT = 7;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] MIN_FRAME_CLKS = 16'h0010;
	localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;
	localparam logic [IDX_W-1:0] GSTAT_IDX = 5'h0c;
	localparam logic [IDX_W-1:0] LOADST_IDX = 5'h0d;
	localparam int GS_PROTO = 7;
	localparam int GS_LOAD = 6;
	localparam int GS_UV = 5;
	localparam int GS_OV = 4;
	localparam int GS_PWRUP = 3;
	localparam int GS_TSD = 2;
	localparam int GS_TPW = 1;
	localparam int GF_W = 5;
	localparam int GF_TPW = 0;
	localparam int GF_TSD = 1;
	localparam int GF_OV = 2;
	localparam int GF_UV = 3;
	localparam int GF_PROTO = 4;
	localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [GF_W-1:0] GFLAG_RESET = 5'h00;
	typedef enum logic [1:0] {
		TX_STAT = 2'b00,
		TX_WAIT = 2'b01,
		TX_RESP = 2'b11,
		TX_DONE = 2'b10
	} spidsf_tx_e;
endpackage

// ===== spidsf_sync.sv
/*
 Two-stage synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; multi-bit words must not be passed through it.
*/
`timescale 1ns/1ps
module spidsf_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} spidsf_sync_s;
	spidsf_sync_s st;
	spidsf_sync_s next_st;
	always_comb begin
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign q_o = st.s2;
endmodule

// ===== spidsf_sticky.sv
/*
 Bank of sticky flags: a set holds the flag until an explicit clear.
 Assumes set and clear are on the same clock; set wins when both arrive together.
*/
`timescale 1ns/1ps
module spidsf_sticky #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Control
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] flag_o
);
	typedef struct packed {
		logic [W-1:0] flag;
	} spidsf_sticky_s;
	spidsf_sticky_s st;
	spidsf_sticky_s next_st;
	always_comb begin
		next_st.flag = set_i | (st.flag & ~clr_i);
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st.flag <= RESET_VAL;
		end else begin
			st <= next_st;
		end
	end
	assign flag_o = st.flag;
endmodule

// ===== spidsf_frontend_sva.sv
/*
 Checker on the ports of the serial front end.
 Assumes it is bound to the front end and sees its ports unchanged.
*/
`timescale 1ns/1ps
module spidsf_frontend_sva
	import spidsf_pkg::*;
#(
	parameter int CTRL_N = 8,
	parameter int LOAD_N = 4
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Link and faults
	input wire logic chip_select_n_i,
	input wire logic serial_out_oe_n_o,
	input wire logic thermal_shutdown_i,
	input wire logic [LOAD_N-1:0] open_load_failure_i,
	input wire logic [LOAD_N-1:0] overcurrent_failure_i,
	// Results
	input wire logic [CTRL_N-1:0][BYTE_W-1:0] ctrl_o,
	input wire logic [BYTE_W-1:0] global_status_o,
	input wire logic global_fault_indicator_o
);
	// Cycles since deselect; frame results must land inside this short window.
	logic [3:0] hi_cnt;
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !chip_select_n_i)
			hi_cnt <= 4'h0;
		else if (hi_cnt != 4'hf)
			hi_cnt <= hi_cnt + 4'h1;
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	AST_OE_TRACKS_SELECT: assert property (serial_out_oe_n_o == chip_select_n_i)
		else $error("output enable differs from select");
	AST_FAULT_SUM: assert property ((chip_select_n_i && $stable(global_status_o)) [*4] |->
		global_fault_indicator_o == (|(global_status_o & 8'hf6) || !global_status_o[GS_PWRUP]))
		else $error("fault indicator disagrees with status");
	AST_LOAD_ERR: assert property ((chip_select_n_i &&
		(|open_load_failure_i || |overcurrent_failure_i)) [*7] |-> global_status_o[GS_LOAD])
		else $error("load error bit missing");
	AST_TSD_SETS: assert property ((chip_select_n_i && thermal_shutdown_i) [*7] |->
		global_status_o[GS_TSD] && global_fault_indicator_o)
		else $error("thermal shutdown not flagged");
	AST_NO_AUTOCLEAR: assert property (|($past(global_status_o) & ~global_status_o) |->
		chip_select_n_i && hi_cnt inside {[4'h1:4'h9]})
		else $error("status bit cleared outside a frame end");
	AST_CTRL_AFTER_FRAME: assert property (!$stable(ctrl_o) |->
		chip_select_n_i && hi_cnt inside {[4'h1:4'h9]})
		else $error("control changed outside a frame end");
	AST_STATUS_FROZEN: assert property ((!chip_select_n_i) [*6] |-> $stable(global_status_o))
		else $error("status snapshot moved inside a frame");
	AST_POWERUP_STATE: assert property ($fell(reset_i) |-> global_fault_indicator_o &&
		!global_status_o[GS_PWRUP] && ctrl_o == '0)
		else $error("wrong state after reset");
	AST_PROTO_AT_END: assert property ($rose(global_status_o[GS_PROTO]) |->
		chip_select_n_i && hi_cnt inside {[4'h1:4'h9]})
		else $error("protocol error raised outside a frame end");
	cover property ($rose(global_status_o[GS_PROTO]));
	cover property (!$stable(ctrl_o));
	cover property ($fell(global_fault_indicator_o));
endmodule
bind spidsf_frontend spidsf_frontend_sva #(.CTRL_N(CTRL_N), .LOAD_N(LOAD_N)) sva (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .chip_select_n_i(chip_select_n_i),
	.serial_out_oe_n_o(serial_out_oe_n_o), .thermal_shutdown_i(thermal_shutdown_i),
	.open_load_failure_i(open_load_failure_i), .overcurrent_failure_i(overcurrent_failure_i),
	.ctrl_o(ctrl_o), .global_status_o(global_status_o),
	.global_fault_indicator_o(global_fault_indicator_o));

// ===== spidsf_master.sv
/*
 Model of the serial master: runs one frame per call, clock still between frames.
 Assumes the device samples on falling and drives on rising clock edges.
*/
`timescale 1ns/1ps
module spidsf_master (
	// Link
	output logic sclk_o,
	output logic csn_o,
	output logic mosi_o,
	input wire logic miso_i
);
	// The link side clears only on a rising select, so the run opens with one.
	initial begin
		sclk_o = 1'b0;
		csn_o = 1'b0;
		mosi_o = 1'b1;
		#1 csn_o = 1'b1;
	end
	// Bit 0 of pol holds the clock high across the opening select edge, bit 1 the closing one.
	task automatic frame(input logic [31:0] tx, input int n, input bit [1:0] pol,
		output logic global_fault_indicator, output logic [31:0] rx);
		rx = '0;
		mosi_o = 1'b0;
		sclk_o = pol[0];
		#113 csn_o = 1'b0;
		#100 sclk_o = 1'b0;
		global_fault_indicator = miso_i;
		for (int i = 0; i < n; i++) begin
			#15 sclk_o = 1'b1;
			mosi_o = tx[i];
			#15 sclk_o = 1'b0;
			rx[i] = miso_i;
		end
		#20 sclk_o = pol[1];
		#100 csn_o = 1'b1;
		#100 sclk_o = 1'b0;
		// A released line must not keep showing the last bit.
		mosi_o = ~mosi_o;
	endtask
endmodule

// ===== spidsf_frontend_bench.sv
/*
 Self-checking bench for the serial front end.
 Assumes the master model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module spidsf_frontend_bench;
	import spidsf_pkg::*;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [11:0] flt = '0;
	logic sclk, chip_select_n, mosi, sout, oe_n, global_fault_indicator, g;
	wire logic miso = oe_n ? 1'bz : sout;
	logic [7:0][7:0] ctrl;
	logic [7:0] gs;
	logic [7:0] mem [8] = '{default: 8'h00};
	logic [31:0] rx;
	logic [7:0] d;
	integer seed = 82;
	int failures = 0;
	int comparisons = 0;
	int k;
	logic [7:0] ea [8] = '{8'h83, 8'h83, 8'h83, 8'hff, 8'h82, 8'h81, 8'h83, 8'h83};
	int en [8] = '{8, 12, 17, 16, 16, 16, 16, 16};
	bit [1:0] ep [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
	always #25 ref_clk_i = ~ref_clk_i;
	spidsf_master m (.sclk_o(sclk), .csn_o(chip_select_n), .mosi_o(mosi), .miso_i(miso));
	spidsf_frontend dut (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .serial_clk_i(sclk),
		.chip_select_n_i(chip_select_n), .serial_in_i(mosi), .serial_out_o(sout),
		.serial_out_oe_n_o(oe_n), .supply_undervoltage_i(flt[0]),
		.supply_overvoltage_i(flt[1]), .thermal_shutdown_i(flt[2]),
		.thermal_warning_i(flt[3]), .open_load_failure_i(flt[7:4]),
		.overcurrent_failure_i(flt[11:8]), .ctrl_o(ctrl), .global_status_o(gs),
		.global_fault_indicator_o(global_fault_indicator));
	function automatic logic [7:0] exp_gs(input logic [11:0] f, input logic pe, input logic pd);
		return {pe, |f[11:4], f[0], f[1], pd, f[2], f[3], 1'b0};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] ad, input logic [7:0] dd, input int n, input bit [1:0] pol);
		m.frame({16'h0000, dd, ad}, n, pol, g, rx);
		repeat (8) @(negedge ref_clk_i);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (3) @(negedge ref_clk_i);
		reset_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		xfer(8'h00, 8'h00, 0, 0);
		chk({7'h0, g}, 8'h01);
		xfer(8'hb3, 8'h00, 16, 0);
		chk(rx[7:0], exp_gs(12'h000, 1'b0, 1'b0));
		xfer(8'h00, 8'h00, 0, 0);
		chk({7'h0, g}, 8'h00);
		for (int i = 0; i < 12; i++) begin
			k = $unsigned($random(seed)) % 8;
			d = 8'($random(seed));
			xfer({1'(i % 3 != 0), 5'(k), 2'b11}, d, 16, 0);
			chk(rx[15:8], mem[k]);
			if (i % 3 != 0)
				mem[k] = d;
			chk(ctrl[k], mem[k]);
		end
		// A byte beyond the data byte comes back as the input delayed by one byte.
		xfer(8'h03, 8'h5a, 24, 0);
		chk(rx[15:8], mem[0]);
		chk(rx[23:16], 8'h5a);
		chk(ctrl[0], mem[0]);
		for (int i = 0; i < 8; i++) begin
			xfer(ea[i], ~mem[0] & 8'hfd, en[i], ep[i]);
			chk(ctrl[0], mem[0]);
			xfer(8'hb3, 8'h00, 16, 0);
			chk(rx[7:0], exp_gs(flt, 1'b1, 1'b1));
		end
		for (int i = 0; i < 6; i++) begin
			flt = (i == 0) ? 12'h010 : 12'($random(seed));
			repeat (10) @(negedge ref_clk_i);
			xfer(8'h00, 8'h00, 0, 0);
			chk({7'h0, g}, {7'h0, |flt});
			xfer(8'hb3, 8'h00, 16, 0);
			chk(rx[7:0], exp_gs(flt, 1'b0, 1'b1));
			d = flt[11:4];
			flt = '0;
			repeat (10) @(negedge ref_clk_i);
			xfer(8'hb7, 8'h00, 16, 0);
			chk(rx[15:8], d);
			xfer(8'hb3, 8'h00, 16, 0);
		end
		reset_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		chk({7'h0, global_fault_indicator}, 8'h01);
		reset_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		xfer(8'h00, 8'h00, 0, 0);
		chk({7'h0, g}, 8'h01);
		end_of_test();
	end
endmodule
